// ==== verilog/lfs_pkg.sv ====
// constants, register map and decode for the link frame statistics counters
package lfs_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  localparam logic [9:0] UPPER_RX_CMD_STAT_HIGH_OFS = 10'h275;
  localparam logic [9:0] UPPER_VALID_CMD_COUNT_LOW_OFS = 10'h276;
  localparam logic [9:0] LOWER_VALID_RSP_COUNT_HIGH_OFS = 10'h277;
  localparam logic [9:0] LOWER_VALID_RSP_COUNT_LOW_OFS = 10'h278;
  localparam logic [9:0] UPPER_SENT_COUNT_HIGH_OFS = 10'h279;
  localparam logic [9:0] UPPER_SENT_COUNT_LOW_OFS = 10'h27a;
  localparam logic [9:0] LOWER_RX_STAT_THIRD_OFS = 10'h26c;
  localparam logic [9:0] COUNT_CTRL_OFS = 10'h26d;
  localparam logic [9:0] COUNT_STATUS_OFS = 10'h26e;

  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_SAT = 16'hffff;

  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_UPPER_EN_BIT = 0;
  localparam int CTRL_LOWER_EN_BIT = 1;
  localparam int STATUS_CMD_SAT_BIT = 0;
  localparam int STATUS_RSP_SAT_BIT = 1;
  localparam int STATUS_SENT_SAT_BIT = 2;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_CMD_HIGH = 4'h1,
    SEL_CMD_LOW = 4'h2,
    SEL_RSP_HIGH = 4'h3,
    SEL_RSP_LOW = 4'h4,
    SEL_SENT_HIGH = 4'h5,
    SEL_SENT_LOW = 4'h6,
    SEL_LOWER_THIRD = 4'h7,
    SEL_CTRL = 4'h8,
    SEL_STATUS = 4'h9
  } lfs_sel_t;

  function automatic lfs_sel_t lfs_decode(input logic [9:0] addr);
    lfs_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      UPPER_RX_CMD_STAT_HIGH_OFS: sel = SEL_CMD_HIGH;
      UPPER_VALID_CMD_COUNT_LOW_OFS: sel = SEL_CMD_LOW;
      LOWER_VALID_RSP_COUNT_HIGH_OFS: sel = SEL_RSP_HIGH;
      LOWER_VALID_RSP_COUNT_LOW_OFS: sel = SEL_RSP_LOW;
      UPPER_SENT_COUNT_HIGH_OFS: sel = SEL_SENT_HIGH;
      UPPER_SENT_COUNT_LOW_OFS: sel = SEL_SENT_LOW;
      LOWER_RX_STAT_THIRD_OFS: sel = SEL_LOWER_THIRD;
      COUNT_CTRL_OFS: sel = SEL_CTRL;
      COUNT_STATUS_OFS: sel = SEL_STATUS;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// ==== verilog/lfs_sat_counter.sv ====
// saturating 16-bit frame counter with synchronous clear
`timescale 1ns/10ps
module lfs_sat_counter
  import lfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic clr,
  output logic [CNT_W-1:0] count,
  output logic saturated
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] countPlusOne;

  assign saturated = (count_reg == CNT_SAT);
  assign countPlusOne = count_reg + CNT_ONE;
  // an event in the clear cycle starts the new period at one
  assign count_next = clr ? (inc ? CNT_ONE : CNT_RESET) :
                      (inc && !saturated) ? countPlusOne : count_reg;
  assign count = count_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ==== verilog/lfs_stat_snapshot.sv ====
// 16-bit snapshot of a counter, split into high and low byte
`timescale 1ns/10ps
module lfs_stat_snapshot
  import lfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] loadValue,
  input wire logic clearLow,
  output logic [DATA_W-1:0] highByte,
  output logic [DATA_W-1:0] lowByte
);

  logic [DATA_W-1:0] high_reg;
  logic [DATA_W-1:0] low_reg;

  assign highByte = high_reg;
  assign lowByte = low_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_reg <= STAT_RESET;
      low_reg <= STAT_RESET;
    end else if (load) begin
      high_reg <= loadValue[15:8];
      low_reg <= loadValue[7:0];
    end else if (clearLow) begin
      low_reg <= STAT_RESET;
    end
  end

endmodule

// ==== verilog/lfs_link_frame_stats.sv ====
// link frame statistics counters with snapshot and read-clear register port
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module lfs_link_frame_stats
  import lfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  input wire logic upperCmdFrameDone,
  input wire logic upperCmdFrameErr,
  input wire logic upperCmdCrcOk,
  input wire logic lowerRspFrameDone,
  input wire logic lowerRspFrameErr,
  input wire logic lowerRspCrcOk,
  input wire logic upperRspSent
);

  // address decode
  lfs_sel_t readSel;
  lfs_sel_t writeSel;
  logic rdCmdHigh;
  logic rdCmdLow;
  logic rdLowerThird;
  logic wrCtrl;

  assign readSel = regRdEn ? lfs_decode(regAddr) : SEL_NONE;
  assign writeSel = regWrEn ? lfs_decode(regAddr) : SEL_NONE;
  assign rdCmdHigh = (readSel == SEL_CMD_HIGH);
  assign rdCmdLow = (readSel == SEL_CMD_LOW);
  assign rdLowerThird = (readSel == SEL_LOWER_THIRD);
  assign wrCtrl = (writeSel == SEL_CTRL);

  // count control
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic upperEnable;
  logic lowerEnable;

  assign ctrl_next = wrCtrl ? regWrData[1:0] : ctrl_reg;
  assign upperEnable = ctrl_reg[CTRL_UPPER_EN_BIT];
  assign lowerEnable = ctrl_reg[CTRL_LOWER_EN_BIT];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // frame qualification
  logic cmdValidEvent;
  logic rspValidEvent;
  logic sentEvent;

  assign cmdValidEvent = upperEnable && upperCmdFrameDone &&
                         !upperCmdFrameErr && upperCmdCrcOk;
  assign rspValidEvent = lowerEnable && lowerRspFrameDone &&
                         !lowerRspFrameErr && lowerRspCrcOk;
  assign sentEvent = upperEnable && upperRspSent;

  // live counters
  logic [CNT_W-1:0] cmdCount;
  logic [CNT_W-1:0] rspCount;
  logic [CNT_W-1:0] sentCount;
  logic cmdSaturated;
  logic rspSaturated;
  logic sentSaturated;
  logic cmdClear;
  logic rspClear;

  assign cmdClear = rdCmdLow;
  assign rspClear = rdLowerThird;

  lfs_sat_counter u_cmd_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(cmdValidEvent),
    .clr(cmdClear),
    .count(cmdCount),
    .saturated(cmdSaturated)
  );

  lfs_sat_counter u_rsp_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(rspValidEvent),
    .clr(rspClear),
    .count(rspCount),
    .saturated(rspSaturated)
  );

  // transmit count runs on; only the snapshot ties it to a period
  lfs_sat_counter u_sent_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(sentEvent),
    .clr(1'b0),
    .count(sentCount),
    .saturated(sentSaturated)
  );

  // snapshots
  logic [DATA_W-1:0] cmdSnapLow;
  logic [DATA_W-1:0] rspSnapHigh;
  logic [DATA_W-1:0] rspSnapLow;
  logic [DATA_W-1:0] sentSnapHigh;
  logic [DATA_W-1:0] sentSnapLow;
  logic upperLatch;
  logic lowerLatch;

  assign upperLatch = rdCmdHigh;
  assign lowerLatch = rdLowerThird;

  lfs_stat_snapshot u_cmd_snap (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(upperLatch),
    .loadValue(cmdCount),
    .clearLow(rdCmdLow),
    .highByte(),
    .lowByte(cmdSnapLow)
  );

  lfs_stat_snapshot u_rsp_snap (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(lowerLatch),
    .loadValue(rspCount),
    .clearLow(1'b0),
    .highByte(rspSnapHigh),
    .lowByte(rspSnapLow)
  );

  lfs_stat_snapshot u_sent_snap (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(upperLatch),
    .loadValue(sentCount),
    .clearLow(1'b0),
    .highByte(sentSnapHigh),
    .lowByte(sentSnapLow)
  );

  // status and read mux
  logic [DATA_W-1:0] statusValue;
  logic [DATA_W-1:0] ctrlValue;
  logic [DATA_W-1:0] readValue;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;

  always_comb begin
    statusValue = READ_ZERO;
    statusValue[STATUS_CMD_SAT_BIT] = cmdSaturated;
    statusValue[STATUS_RSP_SAT_BIT] = rspSaturated;
    statusValue[STATUS_SENT_SAT_BIT] = sentSaturated;
  end

  assign ctrlValue = {6'h00, ctrl_reg};

  // command high byte read returns the live value it latches in the same cycle
  assign readValue = (readSel == SEL_CMD_HIGH) ? cmdCount[15:8] :
                     (readSel == SEL_CMD_LOW) ? cmdSnapLow :
                     (readSel == SEL_RSP_HIGH) ? rspSnapHigh :
                     (readSel == SEL_RSP_LOW) ? rspSnapLow :
                     (readSel == SEL_SENT_HIGH) ? sentSnapHigh :
                     (readSel == SEL_SENT_LOW) ? sentSnapLow :
                     (readSel == SEL_CTRL) ? ctrlValue :
                     (readSel == SEL_STATUS) ? statusValue : READ_ZERO;

  assign rdData_next = regRdEn ? readValue : READ_ZERO;
  assign regRdData = rdData_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= READ_ZERO;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

endmodule

// ==== testbench/lfs_link_frame_stats_chk.sv ====
// concurrent checks on the statistics register port
`timescale 1ns/10ps
module lfs_link_frame_stats_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] regAddr,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic upperCmdFrameDone,
  input wire logic lowerRspFrameDone
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence rd(a);
    regRdEn && regAddr == a;
  endsequence
  idle_zero_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (rd(10'h000) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  cmd_reset_a: assert property (
    rd(10'h275) ##1 rd(10'h276) ##1 rd(10'h275) |=> regRdData == 8'h00)
    else $error("command counter not reset by low read");
  low_clear_a: assert property (
    (rd(10'h276) and !upperCmdFrameDone) ##1 rd(10'h275) ##1 rd(10'h276)
    |=> regRdData == 8'h00)
    else $error("command low byte not cleared");
  sent_hold_a: assert property (
    rd(10'h279) ##1 rd(10'h279) |=> regRdData == $past(regRdData))
    else $error("sent snapshot moved between latches");
  third_zero_a: assert property (rd(10'h26c) |=> regRdData == 8'h00)
    else $error("lower third read not zero");
  lower_reset_a: assert property (
    (rd(10'h26c) and !lowerRspFrameDone) ##1 rd(10'h26c) ##1 rd(10'h277)
    |=> regRdData == 8'h00)
    else $error("lower counter not reset");
  rsp_hold_a: assert property (
    rd(10'h277) ##1 rd(10'h278) ##1 rd(10'h277)
    |=> regRdData == $past(regRdData, 2))
    else $error("response snapshot moved");
endmodule
bind lfs_link_frame_stats lfs_link_frame_stats_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData),
  .upperCmdFrameDone(upperCmdFrameDone), .lowerRspFrameDone(lowerRspFrameDone));

// ==== testbench/lfs_link_peer.sv ====
// neighbour device ending frames on one daisy-chain port
`timescale 1ns/10ps
module lfs_link_peer (
  input wire logic ref_clk,
  input wire logic [1:0] frameKind,
  output logic done,
  output logic err,
  output logic crcOk
);
  // kind 0 idle, 1 good, 2 frame error, 3 bad crc
  logic tog = 1'b0;
  always @(posedge ref_clk) begin
    tog <= ~tog;
    done <= frameKind != 2'h0;
    // flags wander between frames
    err <= (frameKind == 2'h0) ? tog : frameKind == 2'h2;
    crcOk <= (frameKind == 2'h0) ? ~tog : frameKind != 2'h3;
  end
endmodule

// ==== testbench/test_link_frame_statistics_counters.sv ====
// self-checking bench for the link frame statistics counters
`timescale 1ns/10ps
module test_link_frame_statistics_counters;
  import lfs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic rdWas = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [1:0] cmdEv = '0;
  logic [1:0] rspEv = '0;
  logic sentEv = 1'b0;
  logic cD, cE, cC, rD, rE, rC;
  logic en = 1'b1;
  logic [15:0] cmd = '0;
  logic [15:0] rsp = '0;
  logic [15:0] sent = '0;
  logic [7:0] q[$];
  int bad_count = 0;
  int total_checks = 0;
  int seed = 20;
  always #4 ref_clk = ~ref_clk;
  lfs_link_frame_stats u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .upperCmdFrameDone(cD), .upperCmdFrameErr(cE), .upperCmdCrcOk(cC),
    .lowerRspFrameDone(rD), .lowerRspFrameErr(rE), .lowerRspCrcOk(rC), .upperRspSent(sentEv));
  lfs_link_peer u_cmd (.ref_clk(ref_clk), .frameKind(cmdEv), .done(cD), .err(cE), .crcOk(cC));
  lfs_link_peer u_rsp (.ref_clk(ref_clk), .frameKind(rspEv), .done(rD), .err(rE), .crcOk(rC));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    regAddr <= a;
    regRdEn <= 1'b1;
    q.push_back(e);
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regRdEn <= 1'b0;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ev(input logic [1:0] c, input logic [1:0] r, input logic s);
    cmdEv <= c;
    rspEv <= r;
    sentEv <= s;
    regRdEn <= 1'b0;
    if (en && c == 2'h1 && cmd != 16'hffff) cmd++;
    if (en && r == 2'h1 && rsp != 16'hffff) rsp++;
    if (en && s && sent != 16'hffff) sent++;
    @(posedge ref_clk);
  endtask
  task automatic snap;
    rd(10'h26e, {5'h00, sent == 16'hffff, rsp == 16'hffff, cmd == 16'hffff});
    rd(10'h26d, {6'h00, en, en});
    rd(10'h275, cmd[15:8]);
    rd(10'h276, cmd[7:0]);
    rd(10'h275, 8'h00);
    rd(10'h276, 8'h00);
    rd(10'h279, sent[15:8]);
    rd(10'h279, sent[15:8]);
    rd(10'h27a, sent[7:0]);
    rd(10'h26c, 8'h00);
    rd(10'h277, rsp[15:8]);
    rd(10'h278, rsp[7:0]);
    rd(10'h277, rsp[15:8]);
    rd(10'h26c, 8'h00);
    rd(10'h26c, 8'h00);
    rd(10'h277, 8'h00);
    rd(10'h000, 8'h00);
    cmd = '0;
    rsp = '0;
  endtask
  always @(posedge ref_clk) begin
    if (rdWas)
      check(regRdData, q.pop_front());
    rdWas <= regRdEn;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    snap;
    for (int k = 0; k < 4; k++) begin
      if (k == 1) begin
        wr(10'h26d, 8'h00);
        en = 1'b0;
      end
      repeat (300) ev(2'($random(seed)), 2'($random(seed)), 1'($random(seed)));
      repeat (3) ev(2'h0, 2'h0, 1'b0);
      wr(10'h279, 8'($random(seed)));
      snap;
      wr(10'h26d, 8'h03);
      en = 1'b1;
    end
    repeat (65540) ev(2'h1, 2'h1, 1'b1);
    repeat (3) ev(2'h0, 2'h0, 1'b0);
    snap;
    repeat (3) ev(2'h0, 2'h0, 1'b0);
    rst <= 1'b1;
    sent = '0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    snap;
    repeat (3) ev(2'h0, 2'h0, 1'b0);
    close_out;
  end
  initial begin
    #700000;
    bad_count++;
    close_out;
  end
endmodule
